// file: rtl/inband_reset_pkg.sv
package inband_reset_pkg;

  // link pins as seen after the synchroniser
  typedef struct packed {
    logic select_n;
    logic lane;
    logic sck_tog;
  } pin_sample_t;

  localparam int          PIN_W            = 3;
  localparam pin_sample_t PIN_RESET_VAL    = '{select_n: 1'b1, lane: 1'b0, sck_tog: 1'b0};

  localparam int          CLOCK_PERIOD_PS  = 40000;
  // minimum pulse widths the master keeps on its side
  localparam int          SELECT_LOW_MIN_TIME_NS  = 500;
  localparam int          SELECT_HIGH_MIN_TIME_NS = 500;
  // internal reset length, a plain default
  localparam int          RESET_TIME_NS    = 1000;
  localparam int          RESET_CYCLES     =
    (RESET_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  localparam int          PULSE_IDX_W      = 2;
  localparam logic [1:0]  PULSE_IDX_RESET  = 2'h0;
  localparam logic [1:0]  PULSE_IDX_LAST   = 2'h3;
  // low, high, low, high on lane zero, pulse 0 in bit 0 of the expected level
  localparam logic [3:0]  SIGNATURE        = 4'ha;

  typedef enum logic [1:0] {
    ST_WATCH,
    ST_RESETTING
  } detect_state_t;

endpackage : inband_reset_pkg

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import inband_reset_pkg::*;
#(
  parameter int          W         = PIN_W,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage1_next;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage2_next;

  // first stage feeds only the second one
  always_comb begin
    stage1_next = d;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign q = stage2_reg;

endmodule : pin_sync

// file: rtl/in_band_reset_detector.sv
`timescale 1ns/1ps
// Functional notes
// - The reset signature is seen only on the active-low select and data lane zero.
// - Lane zero is taken as it stood when select goes high again.
// - Four pulses must show lane zero low, high, low, high, the value Ah with pulse 0 in bit 0.
// - After the fourth correct pulse the internal reset fires.
// - Lane zero is not driven while select is low until a serial clock edge has occurred.
// - The detector runs whatever the rest of the device is doing.
// - While the internal reset runs, select pulses and commands are ignored.
// - Once the reset ends the device answers normal commands again.
module in_band_reset_detector
  import inband_reset_pkg::*;
#(
  parameter int RESET_LEN = RESET_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic sck,
  input  wire logic select_n,
  input  wire logic data_lane_zero_in,
  input  wire logic stream_req,
  input  wire logic stream_bit,
  output logic      data_lane_zero_out,
  output logic      data_lane_zero_oe,
  output logic      core_reset,
  output logic      link_ready,
  output logic [1:0] detect_progress
);

  localparam int CNT_W = $clog2(RESET_LEN + 1);
  localparam int A_RST_MAX = 1000;

  // ---------------- link clock domain ----------------
  // async clear only because sck may never run before the first frame
  // limitation: two sck edges inside one clock period cancel in the toggle
  logic sck_tog_reg;
  logic sck_tog_next;

  always_comb begin
    sck_tog_next = ~sck_tog_reg;
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      sck_tog_reg <= 1'b0;
    end else begin
      sck_tog_reg <= sck_tog_next;
    end
  end

  // ---------------- crossing into clock ----------------
  pin_sample_t pins_raw;
  pin_sample_t pins_s;

  always_comb begin
    pins_raw.select_n = select_n;
    pins_raw.lane     = data_lane_zero_in;
    pins_raw.sck_tog  = sck_tog_reg;
  end

  pin_sync #(
    .W         (PIN_W),
    .RESET_VAL (PIN_RESET_VAL)
  ) u_pin_sync (
    .clock (clock),
    .rst   (rst),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // ---------------- edge tracking ----------------
  logic select_prev_reg;
  logic select_prev_next;
  logic tog_prev_reg;
  logic tog_prev_next;
  logic lane_held_reg;
  logic lane_held_next;
  logic pulse_clocked_reg;
  logic pulse_clocked_next;
  logic select_rise;
  logic select_fall;
  logic sck_edge;

  always_comb begin
    select_rise        = pins_s.select_n & ~select_prev_reg;
    select_fall        = ~pins_s.select_n & select_prev_reg;
    sck_edge           = pins_s.sck_tog ^ tog_prev_reg;
    select_prev_next   = pins_s.select_n;
    tog_prev_next      = pins_s.sck_tog;
    lane_held_next     = lane_held_reg;
    // lane is taken from the last sample inside the low phase; holds hold time
    if (!pins_s.select_n) begin
      lane_held_next = pins_s.lane;
    end
    pulse_clocked_next = pulse_clocked_reg;
    if (select_fall) begin
      pulse_clocked_next = sck_edge;
    end else if (!pins_s.select_n && sck_edge) begin
      pulse_clocked_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      select_prev_reg   <= 1'b1;
      tog_prev_reg      <= 1'b0;
      lane_held_reg     <= 1'b0;
      pulse_clocked_reg <= 1'b0;
    end else begin
      select_prev_reg   <= select_prev_next;
      tog_prev_reg      <= tog_prev_next;
      lane_held_reg     <= lane_held_next;
      pulse_clocked_reg <= pulse_clocked_next;
    end
  end

  // ---------------- signature detector ----------------
  detect_state_t           state_reg;
  detect_state_t           state_next;
  logic [PULSE_IDX_W-1:0]  pulse_idx_reg;
  logic [PULSE_IDX_W-1:0]  pulse_idx_next;
  logic [CNT_W-1:0]        rst_cnt_reg;
  logic [CNT_W-1:0]        rst_cnt_next;
  logic                    expected;

  // no input from the device core: detection cannot be blocked by any mode
  always_comb begin
    state_next     = state_reg;
    pulse_idx_next = pulse_idx_reg;
    rst_cnt_next   = rst_cnt_reg;
    expected       = SIGNATURE[pulse_idx_reg];
    case (state_reg)
      ST_WATCH: begin
        if (select_rise) begin
          if (pulse_clocked_reg) begin
            pulse_idx_next = PULSE_IDX_RESET;
          end else if (lane_held_reg == expected) begin
            if (pulse_idx_reg == PULSE_IDX_LAST) begin
              state_next     = ST_RESETTING;
              pulse_idx_next = PULSE_IDX_RESET;
              rst_cnt_next   = CNT_W'(RESET_LEN);
            end else begin
              pulse_idx_next = pulse_idx_reg + 2'h1;
            end
          end else if (!lane_held_reg) begin
            // a low level is itself a valid first pulse
            pulse_idx_next = 2'h1;
          end else begin
            pulse_idx_next = PULSE_IDX_RESET;
          end
        end
      end
      ST_RESETTING: begin
        pulse_idx_next = PULSE_IDX_RESET;
        if (rst_cnt_reg <= CNT_W'(1)) begin
          state_next   = ST_WATCH;
          rst_cnt_next = '0;
        end else begin
          rst_cnt_next = rst_cnt_reg - CNT_W'(1);
        end
      end
      default: begin
        state_next     = ST_WATCH;
        pulse_idx_next = PULSE_IDX_RESET;
        rst_cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg     <= ST_WATCH;
      pulse_idx_reg <= PULSE_IDX_RESET;
      rst_cnt_reg   <= '0;
    end else begin
      state_reg     <= state_next;
      pulse_idx_reg <= pulse_idx_next;
      rst_cnt_reg   <= rst_cnt_next;
    end
  end

  // ---------------- outputs ----------------
  logic core_reset_reg;
  logic core_reset_next;
  logic link_ready_reg;
  logic link_ready_next;
  logic lane_oe_reg;
  logic lane_oe_next;
  logic lane_out_reg;
  logic lane_out_next;
  logic [1:0] progress_reg;
  logic [1:0] progress_next;

  always_comb begin
    core_reset_next = (state_next == ST_RESETTING);
    link_ready_next = (state_next == ST_WATCH);
    // never drive before the first clock edge of the frame
    lane_oe_next    = stream_req && link_ready_next && !pins_s.select_n
                      && pulse_clocked_next;
    lane_out_next   = lane_oe_next ? stream_bit : 1'b0;
    progress_next   = pulse_idx_next;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      core_reset_reg <= 1'b0;
      link_ready_reg <= 1'b1;
      lane_oe_reg    <= 1'b0;
      lane_out_reg   <= 1'b0;
      progress_reg   <= 2'h0;
    end else begin
      core_reset_reg <= core_reset_next;
      link_ready_reg <= link_ready_next;
      lane_oe_reg    <= lane_oe_next;
      lane_out_reg   <= lane_out_next;
      progress_reg   <= progress_next;
    end
  end

  assign core_reset         = core_reset_reg;
  assign link_ready         = link_ready_reg;
  assign data_lane_zero_oe  = lane_oe_reg;
  assign data_lane_zero_out = lane_out_reg;
  assign detect_progress    = progress_reg;

  // ---------------- checks ----------------
  logic watching;
  assign watching = (state_reg == ST_WATCH);

  property p_no_drive_unclocked;
    @(posedge clock) disable iff (rst)
      !pulse_clocked_next |=> !data_lane_zero_oe;
  endproperty
  a_no_drive_unclocked: assert property (p_no_drive_unclocked)
    else $error("lane zero driven before a clock edge");

  property p_fire_on_fourth;
    @(posedge clock) disable iff (rst)
      watching && select_rise && !pulse_clocked_reg && pulse_idx_reg == 2'h3
        && lane_held_reg |=> core_reset && !link_ready;
  endproperty
  a_fire_on_fourth: assert property (p_fire_on_fourth)
    else $error("reset not fired after fourth pulse");

  property p_reset_ends;
    @(posedge clock) disable iff (rst)
      $rose(core_reset) |-> ##[1:A_RST_MAX] !core_reset;
  endproperty
  a_reset_ends: assert property (p_reset_ends)
    else $error("internal reset never ends");

  property p_ignore_while_reset;
    @(posedge clock) disable iff (rst)
      core_reset |-> detect_progress == 2'h0 && !data_lane_zero_oe;
  endproperty
  a_ignore_while_reset: assert property (p_ignore_while_reset)
    else $error("activity accepted during reset");

  property p_ready_after;
    @(posedge clock) disable iff (rst)
      $fell(core_reset) |-> link_ready && $past(link_ready) == 1'b0;
  endproperty
  a_ready_after: assert property (p_ready_after)
    else $error("not ready after reset");

  property p_only_on_rise;
    @(posedge clock) disable iff (rst)
      watching && !select_rise |=> $stable(pulse_idx_reg) && !$rose(core_reset);
  endproperty
  a_only_on_rise: assert property (p_only_on_rise)
    else $error("progress moved without a select rise");

  property p_advance;
    @(posedge clock) disable iff (rst)
      watching && select_rise && !pulse_clocked_reg && pulse_idx_reg != 2'h3
        && lane_held_reg == pulse_idx_reg[0] |=> pulse_idx_reg == $past(pulse_idx_reg) + 2'h1;
  endproperty
  a_advance: assert property (p_advance)
    else $error("correct pulse did not advance");

  property p_clocked_restart;
    @(posedge clock) disable iff (rst)
      watching && select_rise && pulse_clocked_reg |=> pulse_idx_reg == 2'h0 && !core_reset;
  endproperty
  a_clocked_restart: assert property (p_clocked_restart)
    else $error("clocked pulse did not restart");

  property p_bad_high;
    @(posedge clock) disable iff (rst)
      watching && select_rise && !pulse_clocked_reg && lane_held_reg
        && !pulse_idx_reg[0] |=> pulse_idx_reg == 2'h0;
  endproperty
  a_bad_high: assert property (p_bad_high)
    else $error("wrong level did not restart");

endmodule : in_band_reset_detector

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic clock,
  output logic      sck,
  output logic      select_n,
  output logic      lane_drv,
  output logic      lane_oe
);
  // link clock rests low outside frames
  initial begin
    sck      = 1'b0;
    select_n = 1'b1;
    lane_drv = 1'b0;
    lane_oe  = 1'b0;
  end

  // two link clock periods of 32 ns
  task automatic clock_burst();
    repeat (4) #16 sck = ~sck;
  endtask : clock_burst

  // one reset-sequence pulse; also issued at wrong levels or clocked to test the detector
  task automatic pulse(input logic level, input logic clocked);
    @(posedge clock);
    select_n <= 1'b0;
    lane_oe  <= 1'b1;
    lane_drv <= level;
    repeat (6) @(posedge clock);
    if (clocked) clock_burst(); // breaks the quiet clock on purpose
    repeat (7) @(posedge clock);
    select_n <= 1'b1;
    repeat (13) @(posedge clock);
    lane_oe  <= 1'b0;
  endtask : pulse

  task automatic open_frame();
    @(posedge clock);
    select_n <= 1'b0;
    lane_oe  <= 1'b0;
  endtask : open_frame

  task automatic close_frame();
    @(posedge clock);
    select_n <= 1'b1;
    repeat (13) @(posedge clock);
  endtask : close_frame
endmodule : host_model

// file: tb/tb.sv
`timescale 1ns/1ps
`define check(name, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[FAIL] %s expected %h seen %h", name, exp, got); \
    end \
  end
module tb;
  import inband_reset_pkg::*;
  localparam int RESET_LEN_TB = 48;
  logic       clock      = 1'b0;
  // raised at time zero so the link-side toggle flop sees a reset edge
  logic       rst        = 1'b0;
  logic       stream_req = 1'b0;
  logic       stream_bit = 1'b1;
  logic       lane_last  = 1'b0;
  logic       sck, select_n, lane_drv, lane_oe, lane_wire;
  logic       dev_out, dev_oe, core_reset, link_ready;
  logic [1:0] detect_progress;
  int         n_fail     = 0;
  int         compares   = 0;
  int         run_len    = 0;
  int         last_run   = 0;

  always #20 clock = ~clock;

  // no pull on the lane: an undriven line flips every cycle
  always_comb begin
    if (lane_oe) lane_wire = lane_drv;
    else if (dev_oe === 1'b1) lane_wire = dev_out;
    else lane_wire = ~lane_last;
  end
  always @(posedge clock) lane_last <= lane_wire;

  always @(posedge clock) begin
    if (core_reset === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_run <= run_len;
      run_len  <= 0;
    end
  end

  host_model u_host_model (.clock(clock), .sck(sck), .select_n(select_n),
    .lane_drv(lane_drv), .lane_oe(lane_oe));

  in_band_reset_detector #(.RESET_LEN(RESET_LEN_TB)) u_in_band_reset_detector (
    .clock(clock), .rst(rst), .sck(sck), .select_n(select_n),
    .data_lane_zero_in(lane_wire), .stream_req(stream_req), .stream_bit(stream_bit),
    .data_lane_zero_out(dev_out), .data_lane_zero_oe(dev_oe), .core_reset(core_reset),
    .link_ready(link_ready), .detect_progress(detect_progress));

  task automatic complete_run();
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic pulse_check(input logic level, input logic clocked, input logic [1:0] exp);
    u_host_model.pulse(level, clocked);
    #1;
    `check("progress", exp, detect_progress)
  endtask : pulse_check

  task automatic run_signature();
    pulse_check(1'b0, 1'b0, 2'h1);
    pulse_check(1'b1, 1'b0, 2'h2);
    pulse_check(1'b0, 1'b0, 2'h3);
    pulse_check(1'b1, 1'b0, 2'h0);
    `check("core_reset", 1'b1, core_reset)
    `check("link_ready", 1'b0, link_ready)
  endtask : run_signature

  task automatic wait_reset_end();
    for (int i = 0; i < 200 && core_reset !== 1'b0; i++) @(posedge clock);
    repeat (2) @(posedge clock);
    #1;
    `check("reset length", RESET_LEN_TB, last_run)
    `check("link_ready", 1'b1, link_ready)
  endtask : wait_reset_end

  task automatic check_reset_values();
    #1;
    `check("oe", 1'b0, dev_oe)
    `check("core_reset", 1'b0, core_reset)
    `check("progress", 2'h0, detect_progress)
  endtask : check_reset_values

  // lane stays released until a link clock edge inside the frame
  task automatic stream_gate();
    @(posedge clock);
    stream_req <= 1'b1;
    u_host_model.open_frame();
    repeat (10) @(posedge clock);
    #1;
    `check("oe before sck", 1'b0, dev_oe)
    u_host_model.clock_burst();
    repeat (8) @(posedge clock);
    #1;
    `check("oe after sck", 1'b1, dev_oe)
    `check("lane out", 1'b1, dev_out)
    @(posedge clock);
    stream_bit <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `check("lane out low", 1'b0, dev_out)
    @(posedge clock);
    stream_req <= 1'b0;
    stream_bit <= 1'b1;
    u_host_model.close_frame();
    #1;
    `check("oe after frame", 1'b0, dev_oe)
    `check("progress", 2'h0, detect_progress)
  endtask : stream_gate

  task automatic sig_and_ignore();
    run_signature();
    u_host_model.pulse(1'b0, 1'b0);
    #1;
    `check("core_reset held", 1'b1, core_reset)
    wait_reset_end();
    `check("progress", 2'h0, detect_progress)
  endtask : sig_and_ignore

  task automatic wrong_levels();
    pulse_check(1'b0, 1'b0, 2'h1);
    pulse_check(1'b0, 1'b0, 2'h1);
    pulse_check(1'b1, 1'b0, 2'h2);
    pulse_check(1'b1, 1'b0, 2'h0);
  endtask : wrong_levels

  task automatic clocked_pulses();
    pulse_check(1'b0, 1'b0, 2'h1);
    pulse_check(1'b1, 1'b1, 2'h0);
    pulse_check(1'b0, 1'b1, 2'h0);
  endtask : clocked_pulses

  // signature arrives while the core wants the lane
  task automatic recover_busy();
    @(posedge clock);
    stream_req <= 1'b1;
    run_signature();
    wait_reset_end();
    @(posedge clock);
    stream_req <= 1'b0;
    stream_gate();
  endtask : recover_busy

  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    complete_run();
  end

  initial begin
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check_reset_values();
    stream_gate();
    sig_and_ignore();
    wrong_levels();
    clocked_pulses();
    recover_busy();
    complete_run();
  end
endmodule : tb
